// ### qpssp_pkg.sv
// ****
// Shared constants for the serial pot port
// ****
package qpssp_pkg;
  localparam int          NUM_POTS         = 4;      // Potentiometers per device
  localparam int          NUM_PRESETS      = 4;      // Preset registers per pot
  localparam int          NUM_TAPS         = 256;    // Taps per pot
  localparam int          DATA_W           = 8;      // Register and byte width
  localparam int          FRAME_BITS       = 24;     // Id, instruction, data bytes
  localparam logic [3:0]  ID_TYPE_CODE     = 4'ha;   // Device type code, value is arbitrary
  localparam logic [7:0]  PRESET_RESET     = 8'h00;  // Preset content after reset
  localparam logic [7:0]  WIPER_RESET      = 8'hff;  // Wiper content before recall, differs from presets
  // Instruction byte layout: op[7:5], zero[4], pot[3:2], preset[1:0]
  localparam int          OP_POS           = 5;
  localparam int          POT_POS          = 2;
  localparam int          IDX_POS          = 0;
  // Id byte layout: type[7:4], zero[3:2], strap address[1:0]
  localparam int          TYPE_POS         = 4;
  localparam int          ADDR_POS         = 0;
  // Operation codes
  localparam logic [2:0]  OP_RD_WIPER      = 3'h0;
  localparam logic [2:0]  OP_WR_WIPER      = 3'h1;
  localparam logic [2:0]  OP_RD_PRESET     = 3'h2;
  localparam logic [2:0]  OP_WR_PRESET     = 3'h3;
  localparam logic [2:0]  OP_RD_STATUS     = 3'h4;
  // Timing
  localparam int          CLK_PERIOD_NS    = 40;
  localparam int          CLK_FREQ_KHZ     = 25000;
  localparam int          NV_WRITE_TIME_MS = 10;     // Longest nonvolatile write
  localparam int          NV_WRITE_CYCLES  = NV_WRITE_TIME_MS * CLK_FREQ_KHZ;
  localparam int          SCK_PERIOD_NS    = 320;    // Serial clock made by the host
  localparam int          SCK_HALF_CYCLES  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int          CS_GAP_CYCLES    = 2 * SCK_HALF_CYCLES;
  // Request word: target[16:15] op[14:12] pot[11:10] idx[9:8] data[7:0]
  localparam int          REQ_W            = 17;
  localparam int          BUF_DEPTH        = 2;
endpackage

// ### qpssp_if.sv
// ****
// Serial link between host and device
// ****
interface qpssp_if;
  logic sck;      // Serial clock from host
  logic cs_n;     // Chip select, active low
  logic si;       // Serial data into device
  logic hold_n;   // Pause request, active low
  logic so;       // Device output data
  logic so_oe;    // Device drives output
  logic so_line;  // Resolved output line level

  // Released line floats high
  assign so_line = so_oe ? so : 1'b1;

  modport dev (input sck, input cs_n, input si, input hold_n, output so, output so_oe);
  modport host (output sck, output cs_n, output si, output hold_n, input so_line);
endinterface

// ### qpssp_buf.sv
// ****
// Small FIFO with valid and ready on both sides
// ****
module qpssp_buf #(
  parameter int WIDTH = qpssp_pkg::REQ_W,
  parameter int DEPTH = qpssp_pkg::BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [PW-1:0]    wr_ptr_reg;   // Write slot
  logic [PW-1:0]    rd_ptr_reg;   // Read slot
  logic [CW-1:0]    count_reg;    // Entries held
  logic [CW-1:0]    count_next;
  logic             push;
  logic             pop;

  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign out_valid  = (count_reg != '0);
  assign out_data   = mem[rd_ptr_reg];
  assign count_next = count_reg + CW'(push) - CW'(pop);

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers, fill count and registered ready
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
      count_reg <= count_next;
      in_ready  <= (count_next != CW'(DEPTH));
    end
  end
endmodule

// ### qpssp_host.sv
// ****
// Host end: queues requests and runs serial frames
// ****
module qpssp_host #(
  parameter int SCK_HALF = qpssp_pkg::SCK_HALF_CYCLES,
  parameter int CS_GAP   = qpssp_pkg::CS_GAP_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  qpssp_if.host           bus,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [1:0] req_target,
  input  wire logic [2:0] req_op,
  input  wire logic [1:0] req_pot,
  input  wire logic [1:0] req_idx,
  input  wire logic [7:0] req_data,
  output logic            rsp_valid,
  output logic      [7:0] rsp_data
);
  typedef enum logic [1:0] {
    HS_IDLE  = 2'h0,
    HS_SHIFT = 2'h1,
    HS_TAIL  = 2'h2,
    HS_GAP   = 2'h3
  } qpssp_hstate_e;

  qpssp_hstate_e                     state_reg;    // Frame sequencer
  logic [qpssp_pkg::REQ_W-1:0]       q_data;       // Head of queue
  logic                              q_valid;      // Queue not empty
  logic                              q_pop;        // Take head
  logic [qpssp_pkg::FRAME_BITS-1:0]  tx_reg;       // Outgoing frame
  logic [7:0]                        rx_reg;       // Incoming bits
  logic [4:0]                        bit_reg;      // Bit index in frame
  logic [7:0]                        div_reg;      // Serial clock divider
  logic                              read_reg;     // Frame expects data back
  logic                              so_meta_reg;  // Output line sync stage one
  logic                              so_sync_reg;  // Output line sync stage two
  logic                              sck_reg;
  logic                              cs_n_reg;
  logic                              si_reg;
  logic                              hold_n_reg;

  assign bus.sck    = sck_reg;
  assign bus.cs_n   = cs_n_reg;
  assign bus.si     = si_reg;
  assign bus.hold_n = hold_n_reg;
  assign q_pop      = (state_reg == HS_IDLE) & q_valid;

  // Request queue; engine pops only when idle
  qpssp_buf #(.WIDTH(qpssp_pkg::REQ_W), .DEPTH(qpssp_pkg::BUF_DEPTH)) u_queue (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_target, req_op, req_pot, req_idx, req_data}),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_data)
  );

  // Device output line synchroniser
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      so_meta_reg <= 1'b1;
      so_sync_reg <= 1'b1;
    end else begin
      so_meta_reg <= bus.so_line;
      so_sync_reg <= so_meta_reg;
    end
  end

  // Pause is never used, so hold stays high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_n_reg <= 1'b1;
    end else begin
      hold_n_reg <= 1'b1;
    end
  end

  // Frame sequencer, divider and shifters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= HS_IDLE;
      tx_reg    <= '0;
      rx_reg    <= '0;
      bit_reg   <= '0;
      div_reg   <= '0;
      read_reg  <= 1'b0;
      sck_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
      si_reg    <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= 1'b0;
      div_reg   <= div_reg + 8'h01;
      case (state_reg)
        // Start a frame with a fresh select fall
        HS_IDLE: begin
          div_reg <= '0;
          if (q_valid) begin
            tx_reg <= {qpssp_pkg::ID_TYPE_CODE, 2'h0, q_data[16:15],
                       q_data[14:12], 1'b0, q_data[11:10], q_data[9:8],
                       q_data[7:0]};
            si_reg    <= qpssp_pkg::ID_TYPE_CODE[3];
            read_reg  <= (q_data[14:12] == qpssp_pkg::OP_RD_WIPER) |
                         (q_data[14:12] == qpssp_pkg::OP_RD_PRESET) |
                         (q_data[14:12] == qpssp_pkg::OP_RD_STATUS);
            cs_n_reg  <= 1'b0;
            bit_reg   <= '0;
            state_reg <= HS_SHIFT;
          end
        end
        // Raise after a low half, sample and drop after a high half
        HS_SHIFT: begin
          if (div_reg == 8'(SCK_HALF - 1)) begin
            div_reg <= '0;
            sck_reg <= ~sck_reg;
            if (sck_reg) begin
              rx_reg <= {rx_reg[6:0], so_sync_reg};
              tx_reg <= {tx_reg[22:0], 1'b0};
              si_reg <= tx_reg[22];
              if (bit_reg == 5'(qpssp_pkg::FRAME_BITS - 1)) begin
                state_reg <= HS_TAIL;
              end else begin
                bit_reg <= bit_reg + 5'h01;
              end
            end
          end
        end
        // Low tail, then release select and report
        HS_TAIL: begin
          if (div_reg == 8'(SCK_HALF - 1)) begin
            div_reg   <= '0;
            cs_n_reg  <= 1'b1;
            rsp_valid <= read_reg;
            rsp_data  <= rx_reg;
            state_reg <= HS_GAP;
          end
        end
        // Select stays high for a gap
        HS_GAP: begin
          if (div_reg == 8'(CS_GAP - 1)) begin
            state_reg <= HS_IDLE;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end
endmodule

// ### qpssp_dev.sv
// Overview of operation
// - Output bits change on serial clock fall
// - Input sampled on serial clock rise
// - Host sends everything over serial input
// - Deselected means output released
// - Standby when deselected, unless write pending
// - Select low makes device active
// - Ignore bus until select falls
// - Hold pauses, keeps partial sequence
// - Host lowers hold only while clock low
// - Host raises hold only while clock low
// - Unused hold stays high
// - Straps give low two address bits
// - Respond only on address match
// - At most four devices, distinct straps
// - Reset recalls first preset into wiper
// - Four pots, wiper plus four presets
// - Wiper selects one of 256 taps
// - Wiper fully decoded to one tap
// - Id byte carries checked type code
// - Presets committed at select rise; pending flag
module qpssp_dev #(
  parameter int NV_CYCLES = qpssp_pkg::NV_WRITE_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  qpssp_if.dev                      bus,
  input  wire logic [1:0]           address_strap_pins,
  output logic      [4*256-1:0]     tap_enable,
  output logic                      standby,
  output logic                      write_pending_flag
);
  localparam int NP = qpssp_pkg::NUM_POTS;
  localparam int NR = qpssp_pkg::NUM_PRESETS;
  localparam int NT = qpssp_pkg::NUM_TAPS;
  localparam int DW = qpssp_pkg::DATA_W;
  localparam int NW = $clog2(NV_CYCLES + 1);

  typedef enum logic [2:0] {
    DS_WAIT  = 3'h0,
    DS_ID    = 3'h1,
    DS_INSTR = 3'h2,
    DS_DATA  = 3'h3,
    DS_DONE  = 3'h4
  } qpssp_dstate_e;

  // ****
  // Input synchronisers and edge detection
  // ****
  // Bits: 0 sck, 1 cs_n, 2 si, 3 hold_n, 5:4 straps
  logic [5:0]    meta_reg;    // First stage
  logic [5:0]    sync_reg;    // Second stage
  logic [1:0]    prev_reg;    // Last sck and cs_n
  logic          sck_rise;
  logic          sck_fall;
  logic          cs_fall;
  logic          cs_rise;
  logic          desel;
  logic          paused;
  logic          rise_ok;
  logic          fall_ok;

  // Select syncs reset low so a select held at reset is no fall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 6'h08;
      sync_reg <= 6'h08;
      prev_reg <= 2'h0;
    end else begin
      meta_reg <= {address_strap_pins, bus.hold_n, bus.si, bus.cs_n, bus.sck};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg[1:0];
    end
  end

  assign sck_rise = sync_reg[0] & ~prev_reg[0];
  assign sck_fall = ~sync_reg[0] & prev_reg[0];
  assign cs_fall  = ~sync_reg[1] & prev_reg[1];
  assign cs_rise  = sync_reg[1] & ~prev_reg[1];
  assign desel    = sync_reg[1];
  assign paused   = ~sync_reg[3];
  assign rise_ok  = sck_rise & ~paused & ~desel;
  assign fall_ok  = sck_fall & ~paused & ~desel;

  // ****
  // Serial receive sequencer
  // ****
  qpssp_dstate_e state_reg;    // Frame position
  logic [2:0]    bit_reg;      // Bit within byte
  logic [DW-1:0] shift_reg;    // Bits received so far
  logic [DW-1:0] instr_reg;    // Instruction byte
  logic [DW-1:0] rx_byte;      // Byte completed this rise
  logic          byte_done;
  logic          id_match;
  logic [2:0]    rx_op;
  logic [2:0]    op;
  logic [1:0]    pot;
  logic [1:0]    idx;
  logic          data_done;

  assign rx_byte   = {shift_reg[DW-2:0], sync_reg[2]};
  assign byte_done = rise_ok & (bit_reg == 3'h7);
  assign id_match  = (rx_byte[7:4] == qpssp_pkg::ID_TYPE_CODE) &
                     (rx_byte[1:0] == sync_reg[5:4]);
  assign rx_op     = rx_byte[qpssp_pkg::OP_POS +: 3];
  assign op        = instr_reg[qpssp_pkg::OP_POS +: 3];
  assign pot       = instr_reg[qpssp_pkg::POT_POS +: 2];
  assign idx       = instr_reg[qpssp_pkg::IDX_POS +: 2];
  assign data_done = byte_done & (state_reg == DS_DATA);

  // Frame state; only a select fall leaves waiting
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= DS_WAIT;
    end else if (desel) begin
      state_reg <= DS_WAIT;
    end else if (cs_fall) begin
      state_reg <= DS_ID;
    end else if (byte_done) begin
      case (state_reg)
        DS_ID:    state_reg <= id_match ? DS_INSTR : DS_DONE;
        DS_INSTR: state_reg <= DS_DATA;
        DS_DATA:  state_reg <= DS_DONE;
        default:  state_reg <= state_reg;  // Waiting or finished: bits ignored
      endcase
    end
  end

  // Bit shifting; paused edges leave counters untouched
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_reg   <= '0;
      shift_reg <= '0;
      instr_reg <= '0;
    end else if (desel | cs_fall) begin
      bit_reg <= '0;
    end else if (rise_ok && state_reg != DS_WAIT && state_reg != DS_DONE) begin
      bit_reg   <= bit_reg + 3'h1;
      shift_reg <= rx_byte;
      if (state_reg == DS_INSTR && bit_reg == 3'h7) begin
        instr_reg <= rx_byte;
      end
    end
  end

  // ****
  // Pot registers
  // ****
  logic [DW-1:0] wiper_position_reg [NP];        // Volatile wiper per pot
  logic [DW-1:0] wiper_preset_regs  [NP][NR];    // Nonvolatile presets per pot
  logic          recall_reg;                     // Recall still to do
  logic          commit_armed_reg;               // Complete preset write held
  logic [DW-1:0] commit_data_reg;
  logic [1:0]    commit_pot_reg;
  logic [1:0]    commit_idx_reg;
  logic [NW-1:0] nv_cnt_reg;                     // Nonvolatile write time left
  logic [DW-1:0] rd_value;                       // Value for a read

  // Read data select by instruction just received
  always_comb begin
    rd_value = '0;
    case (rx_op)
      qpssp_pkg::OP_RD_WIPER:  rd_value = wiper_position_reg[rx_byte[3:2]];
      qpssp_pkg::OP_RD_PRESET: rd_value = wiper_preset_regs[rx_byte[3:2]][rx_byte[1:0]];
      qpssp_pkg::OP_RD_STATUS: rd_value = {7'h00, write_pending_flag};
      default:                 rd_value = '0;
    endcase
  end

  // Wiper: recalled once after reset, then written serially
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      recall_reg <= 1'b1;
      for (int p = 0; p < NP; p++) begin
        wiper_position_reg[p] <= qpssp_pkg::WIPER_RESET;
      end
    end else if (recall_reg) begin
      recall_reg <= 1'b0;
      for (int p = 0; p < NP; p++) begin
        wiper_position_reg[p] <= wiper_preset_regs[p][0];
      end
    end else if (data_done && op == qpssp_pkg::OP_WR_WIPER) begin
      wiper_position_reg[pot] <= rx_byte;
    end
  end

  // Hold a complete preset write until select rises
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      commit_armed_reg <= 1'b0;
      commit_data_reg  <= '0;
      commit_pot_reg   <= '0;
      commit_idx_reg   <= '0;
    end else if (cs_rise | cs_fall) begin
      commit_armed_reg <= 1'b0;
    end else if (data_done && op == qpssp_pkg::OP_WR_PRESET && !write_pending_flag) begin
      commit_armed_reg <= 1'b1;
      commit_data_reg  <= rx_byte;
      commit_pot_reg   <= pot;
      commit_idx_reg   <= idx;
    end
  end

  // Preset store and pending timer; a new write wins over expiry
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      write_pending_flag <= 1'b0;
      nv_cnt_reg         <= '0;
      for (int p = 0; p < NP; p++) begin
        for (int r = 0; r < NR; r++) begin
          wiper_preset_regs[p][r] <= qpssp_pkg::PRESET_RESET;
        end
      end
    end else if (cs_rise && commit_armed_reg) begin
      wiper_preset_regs[commit_pot_reg][commit_idx_reg] <= commit_data_reg;
      write_pending_flag <= 1'b1;
      nv_cnt_reg         <= NW'(NV_CYCLES);
    end else if (write_pending_flag) begin
      nv_cnt_reg <= nv_cnt_reg - NW'(1);
      if (nv_cnt_reg == NW'(1)) begin
        write_pending_flag <= 1'b0;
      end
    end
  end

  // ****
  // Serial output and status outputs
  // ****
  logic [DW-1:0] out_shift_reg;  // Read data left to send
  logic          so_reg;
  logic          so_oe_reg;

  assign bus.so    = so_reg;
  assign bus.so_oe = so_oe_reg;

  // Drive read bits on falls; release when deselected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_shift_reg <= '0;
      so_reg        <= 1'b0;
      so_oe_reg     <= 1'b0;
    end else if (desel) begin
      so_reg    <= 1'b0;
      so_oe_reg <= 1'b0;
    end else if (byte_done && state_reg == DS_INSTR) begin
      out_shift_reg <= rd_value;
    end else if (fall_ok && state_reg == DS_DATA && op != qpssp_pkg::OP_WR_WIPER &&
                 op != qpssp_pkg::OP_WR_PRESET) begin
      so_reg        <= out_shift_reg[DW-1];
      out_shift_reg <= {out_shift_reg[DW-2:0], 1'b0};
      so_oe_reg     <= 1'b1;
    end
  end

  // One-hot tap switch per pot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tap_enable <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        tap_enable[p*NT +: NT] <= NT'(1) << wiper_position_reg[p];
      end
    end
  end

  // Standby only when deselected and no write under way
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      standby <= 1'b0;
    end else begin
      standby <= desel & ~write_pending_flag;
    end
  end
endmodule

// ### qpssp_sva.sv
// ****
// Link checker beside the host-device interface
// ****
module qpssp_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic so_line
);
  logic       sck_reg;       // Serial clock one cycle ago
  logic [4:0] rise_cnt_reg;  // Serial clock rises in this frame

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Counts serial clock rises, cleared while deselected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_reg      <= 1'b0;
      rise_cnt_reg <= 5'h00;
    end else begin
      sck_reg <= sck;
      if (cs_n) begin
        rise_cnt_reg <= 5'h00;
      end else if (sck && !sck_reg) begin
        rise_cnt_reg <= rise_cnt_reg + 5'h01;
      end
    end
  end

  AST_SO_MOVES_WHILE_SCK_LOW: assert property ($changed(so) && $past(so_oe) |-> !sck)
    else $error("output bit moved while serial clock high");
  AST_SI_STABLE_AT_RISE: assert property ($rose(sck) |-> $stable(si))
    else $error("input data moved at serial clock rise");
  AST_RELEASED_WHEN_DESELECTED: assert property (cs_n [*6] |-> !so_oe && so_line)
    else $error("output driven while deselected");
  AST_DRIVE_ONLY_SELECTED: assert property ($rose(so_oe) |-> !cs_n)
    else $error("output enabled without select");
  AST_DRIVE_AFTER_HEADER: assert property ($rose(so_oe) |-> rise_cnt_reg == 5'h10)
    else $error("output enabled before id and instruction bytes");
  AST_FRAME_IS_24_BITS: assert property ($rose(cs_n) |-> rise_cnt_reg == 5'h18)
    else $error("frame length not 24 bits");
  AST_RELEASE_ONLY_ON_DESELECT: assert property ($fell(so_oe) |-> cs_n)
    else $error("output released inside a frame");
  AST_HOLD_UNUSED_HIGH: assert property (hold_n)
    else $error("pause input low");
  AST_SCK_IDLE_LOW: assert property (cs_n |-> !sck)
    else $error("serial clock high outside a frame");

  // Main scenarios
  COV_READ_FRAME: cover property ($rose(so_oe));
  COV_FRAME_DONE: cover property ($rose(cs_n));
  COV_BACK_TO_BACK: cover property ($rose(cs_n) ##[1:20] $fell(cs_n));
endmodule

// ### tb_quad_pot_serial_slave_port.sv
// ****
// Bench: host and device joined over the link
// ****
module tb_quad_pot_serial_slave_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk;          // System clock
  logic          resetn;       // Reset, active low
  logic          req_valid;    // Request strobe
  logic          req_ready;    // Queue has room
  logic [1:0]    req_target;   // Device strap address
  logic [2:0]    req_op;       // Operation code
  logic [1:0]    req_pot;      // Pot number
  logic [1:0]    req_idx;      // Preset number
  logic [7:0]    req_data;     // Write data
  logic          rsp_valid;    // Read answer strobe
  logic [7:0]    rsp_data;     // Read answer
  logic [1:0]    straps;       // Device strap pins
  logic [1023:0] tap_enable;   // Tap selects
  logic          standby;      // Device idle
  logic          pending;      // Nonvolatile write busy
  int            fail_count;   // Mismatches
  int            checks;       // Comparisons
  logic [7:0]    vals [4] = '{8'h5a, 8'hff, 8'h01, 8'h80};  // Wiper values per pot
  logic [7:0]    got;          // Read result

  qpssp_if bus_if ();
  qpssp_host u_qpssp_host (.clk(clk), .resetn(resetn), .bus(bus_if), .req_valid(req_valid),
    .req_ready(req_ready), .req_target(req_target), .req_op(req_op), .req_pot(req_pot),
    .req_idx(req_idx), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  qpssp_dev #(.NV_CYCLES(400)) u_qpssp_dev (.clk(clk), .resetn(resetn), .bus(bus_if),
    .address_strap_pins(straps), .tap_enable(tap_enable), .standby(standby), .write_pending_flag(pending));
  qpssp_sva u_qpssp_sva (.clk(clk), .resetn(resetn), .sck(bus_if.sck), .cs_n(bus_if.cs_n), .si(bus_if.si),
    .hold_n(bus_if.hold_n), .so(bus_if.so), .so_oe(bus_if.so_oe), .so_line(bus_if.so_line));

  // Clock at 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Queue one request, held until the queue takes it
  task automatic send(input logic [1:0] t, input logic [2:0] op, input logic [1:0] p, input logic [1:0] i,
                      input logic [7:0] d);
    int n;
    @(negedge clk);
    {req_valid, req_target, req_op, req_pot, req_idx, req_data} = {1'b1, t, op, p, i, d};
    n = 0;
    while (req_ready !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n == 1000) fail_count++;
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  // Read request, waits for the answer pulse
  task automatic rd(input logic [1:0] t, input logic [2:0] op, input logic [1:0] p, input logic [1:0] i,
                    output logic [7:0] d);
    int n;
    send(t, op, p, i, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n == 2000) fail_count++;
    d = rsp_data;
  endtask

  // Wipers recalled from presets, device idle
  task automatic t_reset();
    repeat (4) @(negedge clk);
    for (int p = 0; p < 4; p++) begin
      check("tap0", {7'h00, tap_enable[p*256]}, 8'h01);
      check("onehot", 8'($countones(tap_enable[p*256+:256])), 8'h01);
    end
    check("standby", {7'h00, standby}, 8'h01);
    check("released", {7'h00, bus_if.so_line}, 8'h01);
    $display("test reset done");
  endtask

  // Back-to-back wiper writes, read back, tap decode
  task automatic t_wiper();
    for (int p = 0; p < 4; p++) send(2'h1, qpssp_pkg::OP_WR_WIPER, 2'(p), 2'h0, vals[p]);
    for (int p = 0; p < 4; p++) begin
      rd(2'h1, qpssp_pkg::OP_RD_WIPER, 2'(p), 2'h0, got);
      check("wiper", got, vals[p]);
      check("tap", {7'h00, tap_enable[p*256+vals[p]]}, 8'h01);
      check("onehot", 8'($countones(tap_enable[p*256+:256])), 8'h01);
    end
    $display("test wiper done");
  endtask

  // Preset commit, pending flag, standby held off
  task automatic t_preset();
    int n;
    send(2'h1, qpssp_pkg::OP_WR_PRESET, 2'h1, 2'h3, 8'hc3);
    rd(2'h1, qpssp_pkg::OP_RD_STATUS, 2'h0, 2'h0, got);
    check("status", got & 8'h01, 8'h01);
    check("standby busy", {7'h00, standby}, 8'h00);
    n = 0;
    while (pending !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check("pending done", {7'h00, pending}, 8'h00);
    rd(2'h1, qpssp_pkg::OP_RD_PRESET, 2'h1, 2'h3, got);
    check("preset3", got, 8'hc3);
    rd(2'h1, qpssp_pkg::OP_RD_PRESET, 2'h1, 2'h0, got);
    check("preset0", got, qpssp_pkg::PRESET_RESET);
    $display("test preset done");
  endtask

  // Wrong strap address ignored, then straps moved
  task automatic t_address();
    send(2'h2, qpssp_pkg::OP_WR_WIPER, 2'h0, 2'h0, 8'h33);
    rd(2'h2, qpssp_pkg::OP_RD_WIPER, 2'h0, 2'h0, got);
    check("no answer", got, 8'hff);
    rd(2'h1, qpssp_pkg::OP_RD_WIPER, 2'h0, 2'h0, got);
    check("unchanged", got, vals[0]);
    @(negedge clk);
    straps = 2'h2;
    repeat (4) @(negedge clk);
    rd(2'h2, qpssp_pkg::OP_RD_WIPER, 2'h0, 2'h0, got);
    check("new strap", got, vals[0]);
    $display("test address done");
  endtask

  // Mid-run reset recalls preset 0 into every written wiper
  task automatic t_recall();
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    for (int p = 0; p < 4; p++) begin
      check("recall", {7'h00, tap_enable[p*256]}, 8'h01);
    end
    $display("test recall done");
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {resetn, req_valid, req_target, req_op, req_pot, req_idx, req_data} = '0;
    straps = 2'h1;
    fail_count = 0;
    checks = 0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_wiper();
    t_preset();
    t_address();
    t_recall();
    stop_test();
  end

  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule
